// ==== rtl/cmbi_bus_master.sv ====
// How it works
// [R1] Upper address byte driven on its own pins, floated in hold, halt, reset.
// [R2] Low address byte driven on shared lines during first state of each cycle.
// [R3] Shared lines carry data in second and third states; we drive on writes.
// [R4] Latch strobe pulses in first state; its fall marks address capture.
// [R5] Outside logic may latch status on the latch strobe's falling edge.
// [R6] Latch strobe is always driven, never floated.
// [R7] Select and status lines set at cycle start, stable to cycle end.
// [R8] High status bit tells read from write before any strobe asserts.
// [R9] Read strobe low asks for data; floated in hold, halt, reset.
// [R10] Write strobe low with data; data still valid when it rises.
// [R11] Addressed party holds ready high when it can finish, low otherwise.
// [R12] Ready low inserts whole wait states until it returns high.
// [R13] Bus request lets the current transfer finish, then buses are released.
// [R14] Queued requests keep being accepted while the bus is granted away.
// [R15] Bus is not retaken until the request input drops.
// [R16] On grant: address, data, strobes and select lines float.
// [R17] Halt plus grant forms power-down, entered and left by the request input.
// [R18] Full address is sixteen bits, covering 64K bytes.
// [R19] Grant ack asserted, bus freed next state; retaken half state after ack drops.
// [R20] Processor clock and clock output are the crystal clock divided by two.
// [R21] Reset clears ack, leaves power-down and floats buses and control lines.
// [R22] Strobes held high outside the data phase while we own the bus.
`include "cmbi_map.svh"

module cmbi_bus_master (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire cmbi_pkg::cmbi_req_type req_word,
    output logic req_ready,
    output logic rsp_valid,
    output logic [`CMBI_BYTE_W-1:0] rsp_rdata,
    input wire logic halt_req,
    output logic clk_out,
    output logic [`CMBI_BYTE_W-1:0] upper_address_byte_o,
    output logic upper_address_byte_oe,
    input wire logic [`CMBI_BYTE_W-1:0] shared_low_addr_data_i,
    output logic [`CMBI_BYTE_W-1:0] shared_low_addr_data_o,
    output logic shared_low_addr_data_oe,
    output logic ale,
    output logic cycle_status_low,
    output logic cycle_status_high,
    output logic io_m_sel_o,
    output logic io_m_sel_oe,
    output logic rd_n_o,
    output logic rd_n_oe,
    output logic wr_n_o,
    output logic wr_n_oe,
    input wire logic ready,
    input wire logic hold,
    output logic bus_grant_ack,
    output logic power_down
);
    import cmbi_pkg::*;

    localparam int REQ_W = $bits(cmbi_req_type);

    typedef struct packed {
        cmbi_phase_type st;
        cmbi_req_type cur;
        logic [`CMBI_BYTE_W-1:0] hi_addr;
        logic hi_oe;
        logic [`CMBI_BYTE_W-1:0] lo_out;
        logic lo_oe;
        logic ale;
        logic [1:0] stat;
        logic io_m;
        logic io_m_oe;
        logic rd_n;
        logic rd_oe;
        logic wr_n;
        logic wr_oe;
        logic ack;
        logic pdown;
        logic rsp_valid;
        logic [`CMBI_BYTE_W-1:0] rsp_data;
    } cmbi_state_type;

    cmbi_state_type q;
    cmbi_state_type d;
    logic t_end;
    logic take_next;
    cmbi_req_type head;

    cmbi_stream_if #(.WIDTH(REQ_W)) q_in ();
    cmbi_stream_if #(.WIDTH(REQ_W)) q_out ();

    // Queue stays open while the bus is away so internal work goes on
    assign q_in.valid = req_valid; // R14
    assign q_in.data = req_word;
    assign req_ready = q_in.ready;
    assign head = cmbi_req_type'(q_out.data);

    cmbi_fifo #(
        .WIDTH(REQ_W),
        .DEPTH(`CMBI_FIFO_DEPTH)
    ) cmbi_fifo_inst (
        .clk(clk),
        .resetn(resetn),
        .in_s(q_in),
        .out_s(q_out)
    );

    cmbi_clk_div cmbi_clk_div_inst (
        .clk(clk),
        .resetn(resetn),
        .clk_out(clk_out), // R20
        .t_end(t_end)
    );

    // A new cycle may start only at a state boundary with no pending request
    assign take_next = t_end && (q.st == ST_IDLE || q.st == ST_T3) && !hold; // R13
    assign q_out.ready = take_next && !halt_req;

    always_comb begin
        d = q;
        d.rsp_valid = 1'b0;
        if (t_end) begin
            case (q.st)
                ST_IDLE, ST_T3: begin
                    if (q.st == ST_T3) begin
                        d.rd_n = 1'b1; // R22
                        d.wr_n = 1'b1;
                        d.lo_oe = 1'b0;
                        if (!q.cur.write) begin
                            d.rsp_valid = 1'b1;
                            d.rsp_data = shared_low_addr_data_i;
                        end
                    end
                    if (hold) begin
                        // Transfer done, acknowledge; shared lines already float, other pins stay driven one more state
                        d.st = ST_HOLD_ACK; // R13
                        d.ack = 1'b1; // R19
                        d.stat = `CMBI_STAT_IDLE;
                    end else if (q_out.valid && !halt_req) begin
                        d.st = ST_T1;
                        d.cur = head;
                        d.hi_addr = head.addr[`CMBI_ADDR_W-1:`CMBI_HI_LSB]; // R1 R18
                        d.hi_oe = 1'b1;
                        d.lo_out = head.addr[`CMBI_HI_LSB-1:0]; // R2
                        d.lo_oe = 1'b1;
                        d.ale = 1'b1; // R4
                        d.io_m = head.io; // R7
                        d.io_m_oe = 1'b1;
                        d.stat = head.write ? `CMBI_STAT_WRITE : `CMBI_STAT_READ; // R8
                    end else if (halt_req) begin
                        d.st = ST_HALT;
                        d.hi_oe = 1'b0; // R1
                        d.lo_oe = 1'b0;
                        d.rd_oe = 1'b0; // R9
                        d.wr_oe = 1'b0; // R10
                        d.io_m_oe = 1'b0;
                        d.stat = `CMBI_STAT_HALT;
                    end else begin
                        d.st = ST_IDLE;
                        d.stat = `CMBI_STAT_IDLE;
                    end
                end
                ST_T1: begin
                    d.st = ST_T2;
                    if (q.cur.write) begin
                        d.lo_out = q.cur.wdata; // R3
                        d.lo_oe = 1'b1;
                        d.wr_n = 1'b0; // R10
                    end else begin
                        d.lo_oe = 1'b0; // R3
                        d.rd_n = 1'b0; // R9
                    end
                end
                ST_T2, ST_TW: begin
                    d.st = ready ? ST_T3 : ST_TW; // R12
                end
                ST_HOLD_ACK: begin
                    d.st = ST_HOLD;
                    d.hi_oe = 1'b0; // R16
                    d.lo_oe = 1'b0;
                    d.rd_oe = 1'b0;
                    d.wr_oe = 1'b0;
                    d.io_m_oe = 1'b0;
                end
                ST_HOLD: begin
                    if (!hold) begin
                        d.st = ST_REGAIN; // R15
                        d.ack = 1'b0; // R19
                    end
                end
                ST_HALT: begin
                    if (hold) begin
                        d.st = ST_PDOWN; // R17
                        d.ack = 1'b1;
                        d.pdown = 1'b1;
                    end else if (!halt_req) begin
                        d.st = ST_IDLE;
                        d.hi_oe = 1'b1;
                        d.rd_oe = 1'b1;
                        d.wr_oe = 1'b1;
                        d.io_m_oe = 1'b1;
                        d.rd_n = 1'b1;
                        d.wr_n = 1'b1;
                        d.stat = `CMBI_STAT_IDLE;
                    end
                end
                ST_PDOWN: begin
                    if (!hold) begin
                        d.st = ST_HALT; // R17
                        d.ack = 1'b0;
                        d.pdown = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end else begin
            case (q.st)
                ST_T1: begin
                    d.ale = 1'b0; // R4
                end
                ST_T3: begin
                    // Strobe rises mid-state while write data is still driven
                    if (q.cur.write) begin
                        d.wr_n = 1'b1; // R10
                    end
                end
                ST_REGAIN: begin
                    d.st = ST_IDLE; // R19
                    d.hi_oe = 1'b1;
                    d.rd_oe = 1'b1;
                    d.wr_oe = 1'b1;
                    d.io_m_oe = 1'b1;
                    d.rd_n = 1'b1; // R22
                    d.wr_n = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.st <= ST_REGAIN; // R21
            q.hi_addr <= `CMBI_RST_ADDR;
            q.hi_oe <= `CMBI_RST_OE;
            q.lo_oe <= `CMBI_RST_OE;
            q.io_m_oe <= `CMBI_RST_OE;
            q.rd_oe <= `CMBI_RST_OE;
            q.wr_oe <= `CMBI_RST_OE;
            q.rd_n <= `CMBI_RST_STROBE;
            q.wr_n <= `CMBI_RST_STROBE;
            q.ack <= 1'b0;
            q.pdown <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign upper_address_byte_o = q.hi_addr;
    assign upper_address_byte_oe = q.hi_oe;
    assign shared_low_addr_data_o = q.lo_out;
    assign shared_low_addr_data_oe = q.lo_oe;
    assign ale = q.ale; // R6
    assign cycle_status_low = q.stat[0]; // R5
    assign cycle_status_high = q.stat[1];
    assign io_m_sel_o = q.io_m;
    assign io_m_sel_oe = q.io_m_oe;
    assign rd_n_o = q.rd_n;
    assign rd_n_oe = q.rd_oe;
    assign wr_n_o = q.wr_n;
    assign wr_n_oe = q.wr_oe;
    assign bus_grant_ack = q.ack;
    assign power_down = q.pdown;
    assign rsp_valid = q.rsp_valid;
    assign rsp_rdata = q.rsp_data;
endmodule // cmbi_bus_master

// ==== rtl/cmbi_map.svh ====
`ifndef CMBI_MAP_SVH
`define CMBI_MAP_SVH

// Address space and byte widths
`define CMBI_ADDR_W 16
`define CMBI_BYTE_W 8
`define CMBI_HI_LSB 8

// Crystal to processor clock ratio
`define CMBI_CLK_DIV 2

// Request queue depth
`define CMBI_FIFO_DEPTH 16

// Cycle status codes, high bit then low bit
`define CMBI_STAT_IDLE 2'h0
`define CMBI_STAT_WRITE 2'h1
`define CMBI_STAT_READ 2'h2
`define CMBI_STAT_HALT 2'h0

// Reset values of pin registers
`define CMBI_RST_ADDR 8'h00
`define CMBI_RST_STROBE 1'h1
`define CMBI_RST_OE 1'h0

`endif

// ==== rtl/cmbi_pkg.sv ====
package cmbi_pkg;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_TW,
        ST_T3,
        ST_HOLD_ACK,
        ST_HOLD,
        ST_REGAIN,
        ST_HALT,
        ST_PDOWN
    } cmbi_phase_type;

    typedef struct packed {
        logic write;
        logic io;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cmbi_req_type;

endpackage

// ==== rtl/cmbi_stream_if.sv ====
interface cmbi_stream_if #(parameter int WIDTH = 26);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/cmbi_clk_div.sv ====
`include "cmbi_map.svh"

module cmbi_clk_div (
    input wire logic clk,
    input wire logic resetn,
    output logic clk_out,
    output logic t_end
);
    typedef struct packed {
        logic phase;
        logic clk_out;
    } cmbi_div_state_type;

    cmbi_div_state_type q;
    cmbi_div_state_type d;

    // Two crystal edges per processor clock state
    always_comb begin
        d = q;
        d.phase = ~q.phase;
        d.clk_out = q.phase;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign clk_out = q.clk_out;
    assign t_end = q.phase;
endmodule // cmbi_clk_div

// ==== rtl/cmbi_fifo.sv ====
module cmbi_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic resetn,
    cmbi_stream_if.snk in_s,
    cmbi_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic full;
        logic empty;
        logic room;
    } cmbi_fifo_state_type;

    cmbi_fifo_state_type q;
    cmbi_fifo_state_type d;
    logic push;
    logic pop;

    always_comb begin
        push = in_s.valid && !q.full;
        pop = out_s.ready && !q.empty;
        d = q;
        if (push) begin
            d.mem[q.wp] = in_s.data;
            d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
        d.full = (d.cnt == (AW + 1)'(DEPTH));
        d.empty = (d.cnt == '0);
        // Registered copy of not-full so the ready output comes from a flop
        d.room = !d.full;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.empty <= 1'b1;
            q.room <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign in_s.ready = q.room;
    assign out_s.valid = !q.empty;
    assign out_s.data = q.mem[q.rp];
endmodule // cmbi_fifo

// ==== dv/cmbi_bus_monitor.sv ====
module cmbi_bus_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ready,
    input wire logic hold,
    input wire logic clk_out,
    input wire logic upper_address_byte_oe,
    input wire logic shared_low_addr_data_oe,
    input wire logic ale,
    input wire logic cycle_status_low,
    input wire logic cycle_status_high,
    input wire logic io_m_sel_o,
    input wire logic io_m_sel_oe,
    input wire logic rd_n_o,
    input wire logic rd_n_oe,
    input wire logic wr_n_o,
    input wire logic wr_n_oe,
    input wire logic bus_grant_ack,
    input wire logic power_down
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_ale_single: assert property ($rose(ale) |=> !ale)
        else $error("ale too long");
    a_addr_phase: assert property (ale |-> clk_out && upper_address_byte_oe
        && shared_low_addr_data_oe && rd_n_o && wr_n_o) else $error("bad address phase");
    a_status_hold: assert property ($rose(ale) |=>
        $stable({cycle_status_high, cycle_status_low, io_m_sel_o}) [*5])
        else $error("status moved");
    a_early_rw: assert property ($fell(rd_n_o) |->
        cycle_status_high && $past(cycle_status_high, 2)) else $error("status late");
    a_wait_ready: assert property ($fell(rd_n_o) ##1 !ready |=> !rd_n_o [*3])
        else $error("no wait state");
    a_float_grant: assert property ($rose(bus_grant_ack) ##2 bus_grant_ack |->
        !upper_address_byte_oe && !shared_low_addr_data_oe && !rd_n_oe && !wr_n_oe
        && !io_m_sel_oe) else $error("bus not released");
    a_keep_grant: assert property (hold && bus_grant_ack |=> bus_grant_ack)
        else $error("grant dropped");
    a_regain_half: assert property ($fell(bus_grant_ack) && !$fell(power_down) |->
        !upper_address_byte_oe ##1 upper_address_byte_oe && rd_n_o) else $error("bad regain");
    a_clk_half: assert property ($past(resetn, 2) |-> $changed(clk_out))
        else $error("clock not halved");
endmodule // cmbi_bus_monitor

bind cmbi_bus_master cmbi_bus_monitor cmbi_bus_monitor_inst (.clk, .resetn, .ready, .hold,
    .clk_out, .upper_address_byte_oe, .shared_low_addr_data_oe, .ale, .cycle_status_low,
    .cycle_status_high, .io_m_sel_o, .io_m_sel_oe, .rd_n_o, .rd_n_oe, .wr_n_o, .wr_n_oe,
    .bus_grant_ack, .power_down);

// ==== dv/cmbi_mem_model.sv ====
module cmbi_mem_model (
    input wire logic clk,
    input wire logic ale,
    input wire logic [7:0] upper_address_byte_o,
    input wire logic [7:0] shared_low_addr_data_o,
    input wire logic shared_low_addr_data_oe,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic cycle_status_high,
    input wire logic [1:0] waits,
    output logic [7:0] shared_low_addr_data_i,
    output logic ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [65536];
    logic [7:0] last = 8'h00;
    logic [15:0] a;
    logic rd;
    int n = 0;
    always @(negedge ale) begin
        a = {upper_address_byte_o, shared_low_addr_data_o};
        rd = cycle_status_high;
    end
    always @(posedge wr_n_o) if (rd === 1'h0) mem[a] = shared_low_addr_data_o;
    always @(posedge clk) begin
        last <= shared_low_addr_data_i;
        n <= (rd_n_o && wr_n_o) ? 0 : n + 1;
    end
    // Released lines toggle so a stale byte is never mistaken for data
    assign shared_low_addr_data_i = shared_low_addr_data_oe ? shared_low_addr_data_o :
        !rd_n_o ? mem[a] : ~last;
    assign ready = (rd_n_o && wr_n_o) || n >= 2 * waits;
endmodule // cmbi_mem_model

// ==== dv/cmbi_bus_master_tb.sv ====
module cmbi_bus_master_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cmbi_pkg::*;
    logic clk = 1'h0, resetn = 1'h0, req_valid = 1'h0, halt_req = 1'h0, hold = 1'h0;
    logic req_ready, rsp_valid, clk_out, upper_address_byte_oe, shared_low_addr_data_oe;
    logic ale, cycle_status_low, cycle_status_high, io_m_sel_o, io_m_sel_oe, ready;
    logic rd_n_o, rd_n_oe, wr_n_o, wr_n_oe, bus_grant_ack, power_down;
    logic [7:0] rsp_rdata, upper_address_byte_o, shared_low_addr_data_i, shared_low_addr_data_o;
    logic [1:0] waits = 2'h0;
    logic [3:0] oes;
    cmbi_req_type req_word = '0;
    cmbi_req_type q[$];
    int miscompares = 0, tests_run = 0, n_ale = 0;

    cmbi_bus_master cmbi_bus_master_inst (.*);
    cmbi_mem_model cmbi_mem_model_inst (.*);

    assign oes = {upper_address_byte_oe, shared_low_addr_data_oe, rd_n_oe, wr_n_oe};
    always #25 clk = ~clk;
    always @(posedge ale) n_ale++;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Streams the queued words, holding valid until each is taken
    task automatic send();
        foreach (q[i]) begin
            req_word = q[i];
            req_valid = 1'h1;
            while (!req_ready) @(negedge clk);
            @(negedge clk);
        end
        req_valid = 1'h0;
        q = {};
    endtask

    task automatic get(input logic [7:0] d, input int cyc);
        int n;
        n = 0;
        while (!rsp_valid) begin
            @(negedge clk);
            n++;
        end
        chk("rdata", rsp_rdata, d);
        if (cyc > 0) chk("latency", 16'(n), 16'(cyc));
        @(negedge clk);
    endtask

    task automatic rst(input int n);
        resetn = 1'h0;
        repeat (n) @(negedge clk);
        chk("float", {oes, io_m_sel_oe, ale, bus_grant_ack, power_down}, 16'h0);
        resetn = 1'h1;
        @(negedge clk);
    endtask

    task automatic t_rw();
        q = '{{1'h1, 1'h0, 16'h12FF, 8'h5A}, {1'h1, 1'h1, 16'hFFFF, 8'hA5},
            {1'h0, 1'h0, 16'h12FF, 8'h00}, {1'h0, 1'h1, 16'hFFFF, 8'h00}};
        send();
        get(8'h5A, 0);
        get(8'hA5, 0);
    endtask

    task automatic t_wait();
        for (int w = 0; w < 3; w += 2) begin
            waits = 2'(w);
            q = '{{1'h0, 1'h0, 16'h12FF, 8'h00}};
            send();
            while (!ale) @(negedge clk);
            get(8'h5A, 6 + 2 * w);
        end
    endtask

    task automatic t_hold();
        int n0;
        hold = 1'h1;
        repeat (8) @(negedge clk);
        chk("ack", bus_grant_ack, 16'h1);
        chk("oes", oes, 16'h0);
        n0 = n_ale;
        for (int i = 0; i < 16; i++) q.push_back({1'h1, 1'h0, 16'(16'h4000 + i), 8'(i)});
        send();
        req_word = {1'h1, 1'h0, 16'h4010, 8'h10};
        req_valid = 1'h1;
        repeat (4) @(negedge clk);
        req_valid = 1'h0;
        chk("full", req_ready, 16'h0);
        chk("held", 16'(n_ale - n0), 16'h0);
        waits = 2'h1;
        hold = 1'h0;
        repeat (200) @(negedge clk);
        chk("drained", 16'(n_ale - n0), 16'h0010);
        q = '{{1'h0, 1'h0, 16'h400F, 8'h00}};
        send();
        get(8'h0F, 0);
    endtask

    task automatic t_halt();
        halt_req = 1'h1;
        repeat (6) @(negedge clk);
        chk("halt", {oes, cycle_status_high, cycle_status_low}, 16'h0);
        hold = 1'h1;
        repeat (6) @(negedge clk);
        chk("pdown", {power_down, bus_grant_ack}, 16'h3);
        hold = 1'h0;
        repeat (6) @(negedge clk);
        chk("wake", {power_down, bus_grant_ack, oes}, 16'h0);
        halt_req = 1'h0;
        repeat (6) @(negedge clk);
        chk("run", oes[3], 16'h1);
    endtask

    initial begin
        rst(16);
        t_rw();
        t_wait();
        t_hold();
        t_halt();
        q = '{{1'h1, 1'h0, 16'h0001, 8'h77}};
        send();
        while (!ale) @(negedge clk);
        rst(2);
        give_verdict();
    end

    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule // cmbi_bus_master_tb
